/* core/ibx_exec.sv */
`timescale 1ns/1ps
// Function
// RULE1: index increment clears upper byte when narrow
// RULE2: indexed memory byte read, add one, write
// RULE3: 8-bit increment sets S Z H PV, N cleared
// RULE4: one-byte register increment opcodes decode
// RULE5: pair increment, upper byte cleared when narrow
// RULE6: pair opcodes 03 13 23, prefix adds cycle
// RULE7: stack increment picks long or short pointer
// RULE8: short and long suffix prefixes accepted
// RULE9: single input: i/o read, store, decrement
// RULE10: block input sets Z on count, N=data bit7
// RULE11: second form also decrements port low byte
// RULE12: repeat form addresses i/o with second pair
// RULE13: repeat until counter zero, cycles 2+3n
// RULE14: variant repeat uses counter address, count byte
// RULE15: mapped form drives port byte, upper zero
// RULE16: mode bit, suffix overrides one instruction only
module ibx_exec (
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_IN,
  // opcode byte stream
  input  wire logic        OP_VALID_IN,
  input  wire logic [7:0]  OP_BYTE_IN,
  output logic             OP_READY_OUT,
  // memory and i/o bus
  output logic             BUS_REQ_OUT,
  output logic             BUS_WR_OUT,
  output logic             BUS_IO_OUT,
  output logic [23:0]      BUS_ADDR_OUT,
  output logic [7:0]       BUS_WDATA_OUT,
  input  wire logic [7:0]  BUS_RDATA_IN,
  input  wire logic        BUS_ACK_IN,
  // instruction completion
  output logic             DONE_OUT,
  output logic [19:0]      CYCLES_OUT,
  // apb register port
  input  wire logic        APB_PSEL_IN,
  input  wire logic        APB_PENABLE_IN,
  input  wire logic        APB_PWRITE_IN,
  input  wire logic [7:0]  APB_PADDR_IN,
  input  wire logic [31:0] APB_PWDATA_IN,
  output logic [31:0]      APB_PRDATA_OUT,
  output logic             APB_PREADY_OUT,
  output logic             APB_PSLVERR_OUT
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    ibx_pkg::ibx_state_type state;
    logic        wide;     // address mode bit
    logic        variant;  // alternate repeat behaviour
    logic        sfx_s;    // short suffix pending
    logic        sfx_l;    // long suffix pending
    logic        use_y;    // index y selected
    logic [1:0]  kind;     // block input kind
    logic [7:0]  acc;
    logic [7:0]  flags;
    logic [23:0] cnt;      // counter pair
    logic [23:0] sec;      // second pair
    logic [23:0] ptr;      // pointer pair
    logic [23:0] idx_x;
    logic [23:0] idx_y;
    logic [23:0] stk_long;
    logic [15:0] stk_short;
    logic [23:0] addr;
    logic [7:0]  wdata;
    logic [7:0]  data;     // byte moved by block input
    logic [19:0] cyc;
    logic        done;
    logic [31:0] prdata;
    logic        slverr;
  } ibx_st_type;

  ibx_st_type st_r;        // registered state
  ibx_st_type st_nxt;      // next state
  logic       eff_wide;    // mode after suffix override
  logic [19:0] sfx_cyc;    // extra cycle for a suffix

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // 8-bit increment result with flags; carry is never touched
  function automatic logic [15:0] inc8(input logic [7:0] v,
                                       input logic [7:0] f);
    logic [7:0] r;
    logic [7:0] g;
    r = v + 8'h01;
    g = f;
    g[ibx_pkg::F_S]  = r[7];
    g[ibx_pkg::F_Z]  = (r == 8'h00);
    g[ibx_pkg::F_H]  = (v[3:0] == 4'hF);
    g[ibx_pkg::F_PV] = (v == 8'h7F);
    g[ibx_pkg::F_N]  = 1'b0;
    return {r, g};
  endfunction

  // multibyte add or subtract one; narrow clears the upper byte
  function automatic logic [23:0] step24(input logic [23:0] v,
                                         input logic w,
                                         input logic up);
    logic [23:0] r;
    r = up ? v + 24'h00_0001 : v - 24'h00_0001;
    return w ? r : {8'h00, r[15:0]};
  endfunction

  // i/o address of a block input transfer
  function automatic logic [23:0] io_addr(input logic [1:0] k,
                                          input logic vr,
                                          input logic [23:0] c,
                                          input logic [23:0] s);
    if (k == ibx_pkg::K_MAPPED) begin
      return {ibx_pkg::UNDEF_UPPER_IO_BYTE, 8'h00, c[7:0]};
    end else if (k == ibx_pkg::K_REPEAT && !vr) begin
      return {ibx_pkg::UNDEF_UPPER_IO_BYTE, s[15:0]};
    end
    return {ibx_pkg::UNDEF_UPPER_IO_BYTE, c[15:0]};
  endfunction

  // suffix state is per instruction; the mode bit persists
  assign eff_wide = st_r.sfx_l | (st_r.wide & ~st_r.sfx_s); // RULE16
  assign sfx_cyc  = (st_r.sfx_s | st_r.sfx_l) ? ibx_pkg::CYC_SFX
                                              : 20'h0_0000;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        fin;
    logic [19:0] fin_cyc;
    logic        zr;
    logic [15:0] ir;
    fin     = 1'b0;
    fin_cyc = 20'h0_0000;
    zr      = 1'b0;
    ir      = 16'h0000;
    st_nxt  = st_r;
    st_nxt.done   = 1'b0;
    st_nxt.slverr = 1'b0;
    // apb setup phase: latch read data and the error answer, so
    // both stand for the whole access phase; exec updates win below
    if (APB_PSEL_IN && !APB_PENABLE_IN) begin
      st_nxt.prdata = 32'h0000_0000;
      st_nxt.slverr = (APB_PADDR_IN[7:6] != 2'b00) ||
                      (APB_PADDR_IN[5:2] > ibx_pkg::R_STATE);
      unique case (APB_PADDR_IN[5:2])
        ibx_pkg::R_CTRL:   st_nxt.prdata[1:0] = {st_r.variant, st_r.wide};
        ibx_pkg::R_FLAGS:  st_nxt.prdata[7:0] = st_r.flags;
        ibx_pkg::R_ACC:    st_nxt.prdata[7:0] = st_r.acc;
        ibx_pkg::R_CNT:    st_nxt.prdata[23:0] = st_r.cnt;
        ibx_pkg::R_SEC:    st_nxt.prdata[23:0] = st_r.sec;
        ibx_pkg::R_PTR:    st_nxt.prdata[23:0] = st_r.ptr;
        ibx_pkg::R_IDXX:   st_nxt.prdata[23:0] = st_r.idx_x;
        ibx_pkg::R_IDXY:   st_nxt.prdata[23:0] = st_r.idx_y;
        ibx_pkg::R_SPLONG: st_nxt.prdata[23:0] = st_r.stk_long;
        ibx_pkg::R_SPSHRT: st_nxt.prdata[15:0] = st_r.stk_short;
        ibx_pkg::R_STATE:  st_nxt.prdata[7:0] = st_r.state;
        default:           st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    // apb access phase: a write to a mapped word other than the state takes effect
    if (APB_PSEL_IN && APB_PENABLE_IN) begin
      if (APB_PWRITE_IN && APB_PADDR_IN[7:6] == 2'b00) begin
        unique case (APB_PADDR_IN[5:2])
          ibx_pkg::R_CTRL: begin
            st_nxt.wide    = APB_PWDATA_IN[0];
            st_nxt.variant = APB_PWDATA_IN[1];
          end
          ibx_pkg::R_FLAGS:  st_nxt.flags    = APB_PWDATA_IN[7:0];
          ibx_pkg::R_ACC:    st_nxt.acc      = APB_PWDATA_IN[7:0];
          ibx_pkg::R_CNT:    st_nxt.cnt      = APB_PWDATA_IN[23:0];
          ibx_pkg::R_SEC:    st_nxt.sec      = APB_PWDATA_IN[23:0];
          ibx_pkg::R_PTR:    st_nxt.ptr      = APB_PWDATA_IN[23:0];
          ibx_pkg::R_IDXX:   st_nxt.idx_x    = APB_PWDATA_IN[23:0];
          ibx_pkg::R_IDXY:   st_nxt.idx_y    = APB_PWDATA_IN[23:0];
          ibx_pkg::R_SPLONG: st_nxt.stk_long  = APB_PWDATA_IN[23:0];
          ibx_pkg::R_SPSHRT: st_nxt.stk_short = APB_PWDATA_IN[15:0];
          default: ;
        endcase
      end
    end
    unique case (st_r.state)
      ibx_pkg::S_FETCH: if (OP_VALID_IN) begin
        fin     = 1'b1;
        fin_cyc = ibx_pkg::CYC_ONE + sfx_cyc;
        unique case (OP_BYTE_IN)
          ibx_pkg::OP_SFX_SHORT: begin // RULE8
            fin = 1'b0;
            st_nxt.sfx_s = 1'b1;
            st_nxt.sfx_l = 1'b0;
          end
          ibx_pkg::OP_SFX_LONG: begin // RULE8
            fin = 1'b0;
            st_nxt.sfx_l = 1'b1;
            st_nxt.sfx_s = 1'b0;
          end
          // single byte register increments, flags per the helper
          8'h3C: {st_nxt.acc, st_nxt.flags} = inc8(st_r.acc, st_r.flags); // RULE4
          8'h04: {st_nxt.cnt[15:8], st_nxt.flags} = inc8(st_r.cnt[15:8], st_r.flags);
          8'h0C: {st_nxt.cnt[7:0], st_nxt.flags} = inc8(st_r.cnt[7:0], st_r.flags);
          8'h14: {st_nxt.sec[15:8], st_nxt.flags} = inc8(st_r.sec[15:8], st_r.flags);
          8'h1C: {st_nxt.sec[7:0], st_nxt.flags} = inc8(st_r.sec[7:0], st_r.flags);
          8'h24: {st_nxt.ptr[15:8], st_nxt.flags} = inc8(st_r.ptr[15:8], st_r.flags);
          8'h2C: {st_nxt.ptr[7:0], st_nxt.flags} = inc8(st_r.ptr[7:0], st_r.flags);
          // pair increments leave every flag alone
          ibx_pkg::OP_PAIR_CNT: st_nxt.cnt = step24(st_r.cnt, eff_wide, 1'b1); // RULE5 RULE6
          ibx_pkg::OP_PAIR_SEC: st_nxt.sec = step24(st_r.sec, eff_wide, 1'b1); // RULE6
          ibx_pkg::OP_PAIR_PTR: st_nxt.ptr = step24(st_r.ptr, eff_wide, 1'b1); // RULE6
          ibx_pkg::OP_INC_STK: begin
            if (eff_wide) begin // RULE7
              st_nxt.stk_long = st_r.stk_long + 24'h00_0001;
            end else begin
              st_nxt.stk_short = st_r.stk_short + 16'h0001;
            end
          end
          ibx_pkg::OP_PFX_X, ibx_pkg::OP_PFX_Y: begin
            fin = 1'b0;
            st_nxt.use_y = (OP_BYTE_IN == ibx_pkg::OP_PFX_Y);
            st_nxt.state = ibx_pkg::S_IDXP;
          end
          ibx_pkg::OP_PFX_EXT: begin
            fin = 1'b0;
            st_nxt.state = ibx_pkg::S_EXT;
          end
          // bytes outside this slice retire with no effect
          default: ;
        endcase
      end
      ibx_pkg::S_IDXP: if (OP_VALID_IN) begin
        fin     = (OP_BYTE_IN != ibx_pkg::OP_INC_MEM);
        fin_cyc = ibx_pkg::CYC_IDX_INC + sfx_cyc;
        if (OP_BYTE_IN == ibx_pkg::OP_PAIR_PTR) begin
          if (st_r.use_y) begin
            st_nxt.idx_y = step24(st_r.idx_y, eff_wide, 1'b1); // RULE1
          end else begin
            st_nxt.idx_x = step24(st_r.idx_x, eff_wide, 1'b1); // RULE1
          end
        end else if (OP_BYTE_IN == ibx_pkg::OP_INC_MEM) begin
          st_nxt.state = ibx_pkg::S_DISP;
        end
      end
      ibx_pkg::S_DISP: if (OP_VALID_IN) begin
        // signed displacement; narrow mode wraps inside 64 KB
        st_nxt.addr = step24((st_r.use_y ? st_r.idx_y : st_r.idx_x) +
                      {{16{OP_BYTE_IN[7]}}, OP_BYTE_IN} + 24'h00_0001,
                      eff_wide, 1'b0); // RULE2
        st_nxt.state = ibx_pkg::S_MRD;
      end
      ibx_pkg::S_MRD: if (BUS_ACK_IN) begin
        ir = inc8(BUS_RDATA_IN, st_r.flags); // RULE2 RULE3
        st_nxt.wdata = ir[15:8];
        st_nxt.flags = ir[7:0];
        st_nxt.state = ibx_pkg::S_MWR;
      end
      ibx_pkg::S_MWR: if (BUS_ACK_IN) begin
        fin     = 1'b1;
        fin_cyc = ibx_pkg::CYC_IDX_MEM + sfx_cyc; // RULE2
      end
      ibx_pkg::S_EXT: if (OP_VALID_IN) begin
        fin     = 1'b1;
        fin_cyc = 20'h0_0002 + sfx_cyc;
        st_nxt.kind = ibx_pkg::K_SINGLE;
        unique case (OP_BYTE_IN)
          ibx_pkg::OP_IO_DEC:   fin = 1'b0; // RULE9
          ibx_pkg::OP_IO_DEC2: begin
            fin = 1'b0;
            st_nxt.kind = ibx_pkg::K_SECOND; // RULE11
          end
          ibx_pkg::OP_IO_DEC2R: begin
            fin = 1'b0;
            st_nxt.kind = ibx_pkg::K_REPEAT; // RULE12
          end
          ibx_pkg::OP_IO_DECM: begin
            fin = 1'b0;
            st_nxt.kind = ibx_pkg::K_MAPPED; // RULE15
          end
          default: ;
        endcase
        if (!fin) begin
          // both single and repeat start at base, then add per pass
          st_nxt.cyc   = (ibx_pkg::CYC_IO_ONE - ibx_pkg::CYC_REP_ITER)
                         + sfx_cyc; // RULE13
          st_nxt.addr  = io_addr(st_nxt.kind, st_r.variant,
                                 st_r.cnt, st_r.sec); // RULE9 RULE14
          st_nxt.state = ibx_pkg::S_IORD;
        end
      end
      ibx_pkg::S_IORD: if (BUS_ACK_IN) begin
        st_nxt.data  = BUS_RDATA_IN;
        st_nxt.wdata = BUS_RDATA_IN;
        st_nxt.addr  = st_r.ptr; // RULE9
        st_nxt.state = ibx_pkg::S_IOWR;
      end
      ibx_pkg::S_IOWR: if (BUS_ACK_IN) begin
        st_nxt.ptr = step24(st_r.ptr, eff_wide, 1'b0);
        st_nxt.cyc = st_r.cyc + ibx_pkg::CYC_REP_ITER;
        if (st_r.kind == ibx_pkg::K_REPEAT && !st_r.variant) begin
          st_nxt.cnt = step24(st_r.cnt, eff_wide, 1'b0); // RULE12
          st_nxt.sec = step24(st_r.sec, eff_wide, 1'b0);
          zr = (st_nxt.cnt == 24'h00_0000);
        end else begin
          st_nxt.cnt[15:8] = st_r.cnt[15:8] - 8'h01; // RULE9
          if (st_r.kind != ibx_pkg::K_SINGLE) begin
            st_nxt.cnt[7:0] = st_r.cnt[7:0] - 8'h01; // RULE11 RULE14
          end
          zr = (st_r.cnt[15:8] == 8'h01);
        end
        st_nxt.flags[ibx_pkg::F_Z] = zr; // RULE10
        st_nxt.flags[ibx_pkg::F_N] = st_r.data[7]; // RULE10
        if (st_r.kind == ibx_pkg::K_REPEAT && !zr) begin
          st_nxt.addr  = io_addr(st_r.kind, st_r.variant,
                                 st_nxt.cnt, st_nxt.sec); // RULE13
          st_nxt.state = ibx_pkg::S_IORD;
        end else begin
          fin     = 1'b1;
          fin_cyc = st_nxt.cyc;
        end
      end
    endcase
    if (fin) begin
      // an instruction ends: suffix override is dropped
      st_nxt.done  = 1'b1;
      st_nxt.cyc   = fin_cyc;
      st_nxt.sfx_s = 1'b0; // RULE16
      st_nxt.sfx_l = 1'b0;
      st_nxt.state = ibx_pkg::S_FETCH;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RESET_IN) begin
      st_r       <= '0;
      st_r.state <= ibx_pkg::S_FETCH;
      st_r.flags <= ibx_pkg::RST_FLAGS;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign OP_READY_OUT = st_r.state inside {ibx_pkg::S_FETCH,
                        ibx_pkg::S_IDXP, ibx_pkg::S_EXT, ibx_pkg::S_DISP};
  assign BUS_REQ_OUT  = st_r.state inside {ibx_pkg::S_MRD,
                        ibx_pkg::S_MWR, ibx_pkg::S_IORD, ibx_pkg::S_IOWR};
  assign BUS_WR_OUT   = st_r.state inside {ibx_pkg::S_MWR,
                                           ibx_pkg::S_IOWR};
  assign BUS_IO_OUT   = (st_r.state == ibx_pkg::S_IORD);
  assign BUS_ADDR_OUT    = st_r.addr;
  assign BUS_WDATA_OUT   = st_r.wdata;
  assign DONE_OUT        = st_r.done;
  assign CYCLES_OUT      = st_r.cyc;
  assign APB_PRDATA_OUT  = st_r.prdata;
  assign APB_PREADY_OUT  = 1'b1;
  assign APB_PSLVERR_OUT = st_r.slverr & APB_PSEL_IN & APB_PENABLE_IN;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RESET_IN);

  logic fetch_take;
  assign fetch_take = (st_r.state == ibx_pkg::S_FETCH) && OP_VALID_IN;

  a_inc_r_done: assert property (fetch_take && OP_BYTE_IN == 8'h3C &&
    !st_r.sfx_s && !st_r.sfx_l |=> DONE_OUT && CYCLES_OUT == 20'h0_0001)
    else $error("register increment not done in one cycle"); // RULE4
  a_pv_on_7f: assert property (fetch_take && OP_BYTE_IN == 8'h3C &&
    st_r.acc == 8'h7F |=> st_r.flags[ibx_pkg::F_PV] &&
    st_r.flags[ibx_pkg::F_S] && !st_r.flags[ibx_pkg::F_N] &&
    st_r.flags[ibx_pkg::F_C] == $past(st_r.flags[ibx_pkg::F_C]))
    else $error("increment flags wrong for 7F"); // RULE3
  a_pair_narrow: assert property (fetch_take &&
    OP_BYTE_IN == ibx_pkg::OP_PAIR_CNT && !eff_wide
    |=> st_r.cnt[23:16] == 8'h00 && $stable(st_r.flags))
    else $error("pair increment upper byte or flags"); // RULE5
  a_pair_sfx_cyc: assert property (fetch_take &&
    OP_BYTE_IN == ibx_pkg::OP_PAIR_SEC && (st_r.sfx_s || st_r.sfx_l)
    |=> CYCLES_OUT == 20'h0_0002 && !st_r.sfx_s && !st_r.sfx_l)
    else $error("suffixed pair increment cycles"); // RULE6
  a_idx_narrow: assert property (st_r.state == ibx_pkg::S_IDXP &&
    OP_VALID_IN && OP_BYTE_IN == ibx_pkg::OP_PAIR_PTR && !eff_wide &&
    !st_r.use_y |=> st_r.idx_x[23:16] == 8'h00 && DONE_OUT)
    else $error("index increment upper byte"); // RULE1
  a_io_addr_cnt: assert property (st_r.state == ibx_pkg::S_IORD &&
    st_r.kind == ibx_pkg::K_SINGLE |-> BUS_IO_OUT &&
    BUS_ADDR_OUT[15:0] == st_r.cnt[15:0])
    else $error("single input i/o address"); // RULE9
  a_mapped_addr: assert property (st_r.state == ibx_pkg::S_IORD &&
    st_r.kind == ibx_pkg::K_MAPPED |-> BUS_ADDR_OUT[15:8] == 8'h00 &&
    BUS_ADDR_OUT[7:0] == st_r.cnt[7:0])
    else $error("mapped input address"); // RULE15
  a_n_from_data: assert property (st_r.state == ibx_pkg::S_IOWR &&
    BUS_ACK_IN |=> st_r.flags[ibx_pkg::F_N] == $past(st_r.data[7]) &&
    st_r.ptr[15:0] == $past(st_r.ptr[15:0]) - 16'h0001)
    else $error("block input flag or pointer"); // RULE10
  a_rep_addr_sec: assert property (st_r.state == ibx_pkg::S_IORD &&
    st_r.kind == ibx_pkg::K_REPEAT && !st_r.variant
    |-> BUS_ADDR_OUT[15:0] == st_r.sec[15:0])
    else $error("repeat input address"); // RULE12

  c_rep_loop: cover property (st_r.state == ibx_pkg::S_IOWR &&
    BUS_ACK_IN && st_r.kind == ibx_pkg::K_REPEAT ##1
    st_r.state == ibx_pkg::S_IORD);
  c_idx_mem: cover property (st_r.state == ibx_pkg::S_MWR &&
    BUS_ACK_IN ##1 DONE_OUT);
  c_sfx_short: cover property (fetch_take &&
    OP_BYTE_IN == ibx_pkg::OP_SFX_SHORT && st_r.wide);
endmodule

/* dv/ibx_bus_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------
// memory and i/o peripherals on the far side of the cpu bus
// ----------------------------------------------------------------
module ibx_bus_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // access from the block
  input  wire logic        req,
  input  wire logic        wr,
  input  wire logic        io,
  input  wire logic [23:0] addr,
  input  wire logic [7:0]  wdata,
  // wait cycles before each answer
  input  wire logic [3:0]  dly,
  // answer
  output logic      [7:0]  rdata,
  output logic             ack
);
  logic [7:0] mem [256]; // only the low address byte decodes
  logic [3:0] cnt;       // wait cycles spent on this access
  initial for (int i = 0; i < 256; i++) mem[i] = 8'h7F;
  // prompt or slow answer; the data line scrambles outside an answer
  // so a stale byte shows up inverted, but only on alternate cycles
  always @(posedge clk) begin
    ack   <= 1'b0;
    rdata <= ~rdata;
    if (rst) begin
      cnt   <= 4'h0;
      rdata <= 8'h00;
    end else if (req && !ack) begin
      if (cnt == dly) begin
        cnt <= 4'h0;
        ack <= 1'b1;
        if (wr) mem[addr[7:0]] <= wdata;
        else rdata <= io ? (addr[7:0] ^ 8'h80) : mem[addr[7:0]];
      end else cnt <= cnt + 4'h1;
    end
  end
endmodule

/* dv/increment_and_block_input_exec_bench.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  err_count++; $display("Error %0t: got %h exp %h", $time, a, b); end end
module increment_and_block_input_exec_bench;
  logic clk = 0, rst = 1, ov = 0, psel = 0, pen = 0, pw = 0, req, wr, io;
  logic ack, done, rdy, prdy, perr, apb_err;
  logic [7:0] ob = 8'h00, pa = 8'h00, wd, rd;
  logic [31:0] pwd = 32'h0000_0000, prd, r;
  logic [23:0] ad;
  logic [19:0] cyc;
  logic [3:0]  dly = 4'h0;
  int err_count = 0, samples_checked = 0, ticks = 0;
  always #2.5 clk = ~clk;
  ibx_exec dut (.CLK_IN(clk), .RESET_IN(rst), .OP_VALID_IN(ov),
    .OP_BYTE_IN(ob), .OP_READY_OUT(rdy), .BUS_REQ_OUT(req),
    .BUS_WR_OUT(wr), .BUS_IO_OUT(io), .BUS_ADDR_OUT(ad),
    .BUS_WDATA_OUT(wd), .BUS_RDATA_IN(rd), .BUS_ACK_IN(ack),
    .DONE_OUT(done), .CYCLES_OUT(cyc), .APB_PSEL_IN(psel),
    .APB_PENABLE_IN(pen), .APB_PWRITE_IN(pw), .APB_PADDR_IN(pa),
    .APB_PWDATA_IN(pwd), .APB_PRDATA_OUT(prd), .APB_PREADY_OUT(prdy),
    .APB_PSLVERR_OUT(perr));
  ibx_bus_model mdl (.clk(clk), .rst(rst), .req(req), .wr(wr), .io(io),
    .addr(ad), .wdata(wd), .dly(dly), .rdata(rd), .ack(ack));
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard: the whole run needs well under this many cycles
  always @(posedge clk) begin
    ticks++;
    if (ticks == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // one apb transfer, request held until pready is seen high
  task automatic apb(input logic w, input logic [3:0] i,
                     input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1; pen <= 1'b0; pw <= w; pa <= {2'b00, i, 2'b00}; pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    // pready, read data and error are taken as they stand at the edge
    do @(posedge clk); while (prdy !== 1'b1);
    q = prd;
    apb_err = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge clk);
  endtask
  // one stream byte, held until the block takes it
  task automatic op(input logic [7:0] b);
    ov <= 1'b1;
    ob <= b;
    do @(posedge clk); while (rdy !== 1'b1);
  endtask
  // wait for retirement and judge the reported cycle count
  task automatic fin(input logic [19:0] n);
    ov <= 1'b0;
    for (int k = 0; k < 60; k++) begin
      #1;
      if (done === 1'b1) break;
      @(posedge clk);
    end
    `CHK(done, 1'b1)
    `CHK(cyc, n)
    @(posedge clk);
  endtask
  task automatic t_inc_acc();
    apb(1, ibx_pkg::R_ACC, 32'h0000_007F, r);
    apb(1, ibx_pkg::R_FLAGS, 32'h0000_0001, r);
    op(8'h3C);
    fin(20'h0_0001);
    apb(0, ibx_pkg::R_ACC, 32'h0000_0000, r);
    `CHK(r[7:0], 8'h80)
    apb(0, ibx_pkg::R_FLAGS, 32'h0000_0000, r);
    `CHK(r[7:0], 8'h95)
  endtask
  // short suffix in wide mode, then the mode applies again
  task automatic t_pairs();
    apb(1, ibx_pkg::R_CTRL, 32'h0000_0001, r);
    apb(1, ibx_pkg::R_CNT, 32'h0012_FFFF, r);
    apb(1, ibx_pkg::R_SEC, 32'h0012_FFFF, r);
    op(8'h52);
    op(8'h03);
    fin(20'h0_0002);
    op(8'h13);
    fin(20'h0_0001);
    apb(1, ibx_pkg::R_IDXX, 32'h0012_FFFF, r);
    op(8'h33);
    fin(20'h0_0001);
    op(8'h52);
    op(8'hDD);
    op(8'h23);
    fin(20'h0_0003);
    apb(0, ibx_pkg::R_CNT, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_0000)
    apb(0, ibx_pkg::R_SEC, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h13_0000)
    apb(0, ibx_pkg::R_FLAGS, 32'h0000_0000, r);
    `CHK(r[7:0], 8'h95)
    apb(0, ibx_pkg::R_SPLONG, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_0001)
    apb(0, ibx_pkg::R_IDXX, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_0000)
  endtask
  // negative displacement, slow memory
  task automatic t_idx_mem();
    dly <= 4'h2;
    apb(1, ibx_pkg::R_CTRL, 32'h0000_0000, r);
    apb(1, ibx_pkg::R_IDXX, 32'h0000_0010, r);
    op(8'hDD);
    op(8'h34);
    op(8'hFE);
    fin(20'h0_0006);
    `CHK(mdl.mem[8'h0E], 8'h80)
  endtask
  // two repeated i/o transfers, i/o address from the second pair
  task automatic t_repeat();
    dly <= 4'h1;
    apb(1, ibx_pkg::R_SEC, 32'h0000_0040, r);
    apb(1, ibx_pkg::R_PTR, 32'h0000_0020, r);
    apb(1, ibx_pkg::R_CNT, 32'h0000_0002, r);
    op(8'hED);
    op(8'h9C);
    fin(20'h0_0008);
    `CHK(mdl.mem[8'h20], 8'hC0)
    `CHK(mdl.mem[8'h1F], 8'hBF)
    apb(0, ibx_pkg::R_SEC, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_003E)
    apb(0, ibx_pkg::R_PTR, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_001E)
    apb(0, ibx_pkg::R_FLAGS, 32'h0000_0000, r);
    `CHK(r[7:0], 8'hD7)
    apb(0, 4'hC, 32'h0000_0000, r);
    `CHK(apb_err, 1'b1)
  endtask
  // mapped, second and single forms, then the variant repeat
  task automatic t_io();
    apb(1, ibx_pkg::R_CNT, 32'h0000_0203, r);
    apb(1, ibx_pkg::R_PTR, 32'h0000_0050, r);
    op(8'hED);
    op(8'h8A);
    fin(20'h0_0005);
    op(8'hED);
    op(8'h8C);
    fin(20'h0_0005);
    op(8'h49);
    op(8'hED);
    op(8'hAA);
    fin(20'h0_0006);
    apb(0, ibx_pkg::R_CNT, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_FF01)
    apb(0, ibx_pkg::R_FLAGS, 32'h0000_0000, r);
    `CHK(r[7:0], 8'h97)
    apb(1, ibx_pkg::R_CTRL, 32'h0000_0002, r);
    apb(1, ibx_pkg::R_CNT, 32'h0000_0204, r);
    op(8'hED);
    op(8'h9C);
    fin(20'h0_0008);
    `CHK({mdl.mem[8'h50], mdl.mem[8'h4F]}, 16'h8382)
    `CHK({mdl.mem[8'h4E], mdl.mem[8'h4D]}, 16'h8184)
    `CHK(mdl.mem[8'h4C], 8'h83)
    apb(0, ibx_pkg::R_CNT, 32'h0000_0000, r);
    `CHK(r[23:0], 24'h00_0002)
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_inc_acc();
    t_pairs();
    t_idx_mem();
    t_repeat();
    t_io();
    tally_and_finish();
  end
endmodule

/* include/ibx_pkg.sv */
package ibx_pkg;
  // ----------------------------------------------------------------
  // controller states (one-hot)
  // ----------------------------------------------------------------
  typedef enum logic [7:0] {
    S_FETCH = 8'b0000_0001, // first opcode byte or suffix prefix
    S_IDXP  = 8'b0000_0010, // after an index prefix byte
    S_EXT   = 8'b0000_0100, // after the extended prefix byte
    S_DISP  = 8'b0000_1000, // waiting for the displacement byte
    S_MRD   = 8'b0001_0000, // indexed memory read
    S_MWR   = 8'b0010_0000, // indexed memory write back
    S_IORD  = 8'b0100_0000, // block input: i/o read
    S_IOWR  = 8'b1000_0000  // block input: memory write
  } ibx_state_type;

  // ----------------------------------------------------------------
  // opcodes and prefixes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SFX_SHORT = 8'h52;
  localparam logic [7:0] OP_SFX_LONG  = 8'h49;
  localparam logic [7:0] OP_PFX_X     = 8'hDD;
  localparam logic [7:0] OP_PFX_Y     = 8'hFD;
  localparam logic [7:0] OP_PFX_EXT   = 8'hED;
  localparam logic [7:0] OP_PAIR_CNT  = 8'h03;
  localparam logic [7:0] OP_PAIR_SEC  = 8'h13;
  localparam logic [7:0] OP_PAIR_PTR  = 8'h23;
  localparam logic [7:0] OP_INC_STK   = 8'h33;
  localparam logic [7:0] OP_INC_MEM   = 8'h34;
  localparam logic [7:0] OP_IO_DEC    = 8'hAA;
  localparam logic [7:0] OP_IO_DEC2   = 8'h8C;
  localparam logic [7:0] OP_IO_DEC2R  = 8'h9C;
  localparam logic [7:0] OP_IO_DECM   = 8'h8A;

  // block input kinds
  localparam logic [1:0] K_SINGLE = 2'd0;
  localparam logic [1:0] K_SECOND = 2'd1;
  localparam logic [1:0] K_REPEAT = 2'd2;
  localparam logic [1:0] K_MAPPED = 2'd3;

  // ----------------------------------------------------------------
  // flag bit positions
  // ----------------------------------------------------------------
  localparam int F_S  = 7;
  localparam int F_Z  = 6;
  localparam int F_H  = 4;
  localparam int F_PV = 2;
  localparam int F_N  = 1;
  localparam int F_C  = 0;

  // ----------------------------------------------------------------
  // instruction cycle figures
  // ----------------------------------------------------------------
  localparam logic [19:0] CYC_ONE      = 20'h0_0001;
  localparam logic [19:0] CYC_IDX_INC  = 20'h0_0002;
  localparam logic [19:0] CYC_IDX_MEM  = 20'h0_0006;
  localparam logic [19:0] CYC_IO_ONE   = 20'h0_0005;
  localparam logic [19:0] CYC_REP_BASE = 20'h0_0002;
  localparam logic [19:0] CYC_REP_ITER = 20'h0_0003;
  localparam logic [19:0] CYC_SFX      = 20'h0_0001;

  // upper i/o address byte is undefined; driven as this value
  localparam logic [7:0] UNDEF_UPPER_IO_BYTE = 8'h00;

  // ----------------------------------------------------------------
  // register word indexes (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam logic [3:0] R_CTRL   = 4'h0; // bit0 wide, bit1 variant
  localparam logic [3:0] R_FLAGS  = 4'h1;
  localparam logic [3:0] R_ACC    = 4'h2;
  localparam logic [3:0] R_CNT    = 4'h3;
  localparam logic [3:0] R_SEC    = 4'h4;
  localparam logic [3:0] R_PTR    = 4'h5;
  localparam logic [3:0] R_IDXX   = 4'h6;
  localparam logic [3:0] R_IDXY   = 4'h7;
  localparam logic [3:0] R_SPLONG = 4'h8;
  localparam logic [3:0] R_SPSHRT = 4'h9;
  localparam logic [3:0] R_STATE  = 4'hA; // read only
  localparam logic [7:0] RST_FLAGS = 8'h00;
endpackage
